// ---- shared/bit_ops_defs.vh ----
// Constants for the single-bit set and clear instruction unit.
// What this block does
// - Opcode 1000 1bbb ffff ffff writes 0 into bit b of register f and keeps the other bits.
// - Opcode 1000 0bbb ffff ffff writes 1 into bit b of register f and keeps the other bits.
// - The register address is the low 8 bits of the word, any value 0 to 255 in the bank.
// - A 3-bit index field picks bit 0 to 7 of the addressed register.
`ifndef BIT_OPS_DEFS_VH
`define BIT_OPS_DEFS_VH

// ----------------------------------------------------------------
// Instruction fields
// ----------------------------------------------------------------
`define OPC_HI      15
`define OPC_LO      12
`define OPC_BITOP   4'h8
`define SEL_POS     11
`define IDX_HI      10
`define IDX_LO      8
`define ADDR_HI     7
`define ADDR_LO     0

// ----------------------------------------------------------------
// Phase codes, one-hot
// ----------------------------------------------------------------
`define PH_DECODE   4'h1
`define PH_READ     4'h2
`define PH_MODIFY   4'h4
`define PH_WRITE    4'h8

`endif

// ---- src/bit_modify.v ----
// Combinational single-bit modify of one data byte.
`timescale 1ns/1ps
module bit_modify #(
  parameter W  = 8,
  parameter IW = 3
) (
  input  wire [W-1:0]  data_in,
  input  wire [IW-1:0] idx_in,
  input  wire          set_in,
  output reg  [W-1:0]  data_out
);
  integer i;
  always @* begin
    data_out = data_in;
    for (i = 0; i < W; i = i + 1) begin
      if (idx_in == i[IW-1:0]) begin
        data_out[i] = set_in;
      end
    end
  end
endmodule // bit_modify

// ---- src/bit_op_unit.v ----
// Decode and execute unit for the bit set and bit clear instructions.
`timescale 1ns/1ps
`include "bit_ops_defs.vh"
module bit_op_unit #(
  parameter AW = 8,
  parameter DW = 8
) (
  // Clock and reset
  input  wire          SYS_CLK_IN,
  input  wire          RSTN_IN,
  // Instruction issue
  input  wire          INSTR_VALID_IN,
  input  wire [15:0]   INSTR_IN,
  output wire          INSTR_READY_OUT,
  // Register file read
  output reg  [AW-1:0] RD_ADDR_OUT,
  output reg           RD_EN_OUT,
  input  wire [DW-1:0] RD_DATA_IN,
  // Register file write
  output reg  [AW-1:0] WR_ADDR_OUT,
  output reg  [DW-1:0] WR_DATA_OUT,
  output reg           WR_EN_OUT,
  // Status
  output wire          BUSY_OUT,
  output reg           DONE_OUT
);

  // ----------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------
  // The sequencer free-runs: an instruction cycle is always four phases, so the
  // issuing side can count on a fixed slot even when a word is not acted on.
  localparam [3:0] ST_DECODE = `PH_DECODE;
  localparam [3:0] ST_READ   = `PH_READ;
  localparam [3:0] ST_MODIFY = `PH_MODIFY;
  localparam [3:0] ST_WRITE  = `PH_WRITE;
  localparam       IW        = `IDX_HI - `IDX_LO + 1;

  reg  [3:0]    phase_q;
  reg  [3:0]    phase_d;
  wire          in_decode;
  wire          in_read;
  wire          in_modify;
  wire          in_write;

  assign in_decode = (phase_q == ST_DECODE);
  assign in_read   = (phase_q == ST_READ);
  assign in_modify = (phase_q == ST_MODIFY);
  assign in_write  = (phase_q == ST_WRITE);

  always @* begin
    case (phase_q)
      ST_DECODE: begin
        phase_d = ST_READ;
      end
      ST_READ: begin
        phase_d = ST_MODIFY;
      end
      ST_MODIFY: begin
        phase_d = ST_WRITE;
      end
      ST_WRITE: begin
        phase_d = ST_DECODE;
      end
      default: begin
        // An illegal code, which only an upset can cause, restarts at decode.
        phase_d = ST_DECODE;
      end
    endcase
  end

  always @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      phase_q <= ST_DECODE;
    end else begin
      phase_q <= phase_d;
    end
  end

  // ----------------------------------------------------------------
  // Instruction fields
  // ----------------------------------------------------------------
  wire          is_bit_op;
  wire          take;
  wire [AW-1:0] field_addr;
  wire [IW-1:0] field_idx;
  wire          field_clear;

  assign is_bit_op       = (INSTR_IN[`OPC_HI:`OPC_LO] == `OPC_BITOP);
  assign field_addr      = INSTR_IN[`ADDR_HI:`ADDR_LO];
  assign field_idx       = INSTR_IN[`IDX_HI:`IDX_LO];
  assign field_clear     = INSTR_IN[`SEL_POS];
  // Only one instruction is held at a time; a new one is taken in the decode phase.
  assign INSTR_READY_OUT = in_decode;
  // Words outside the bit group still use up their slot; they are simply not acted on.
  assign take            = in_decode && INSTR_VALID_IN && is_bit_op;

  // ----------------------------------------------------------------
  // Operand capture
  // ----------------------------------------------------------------
  reg           active_q;
  reg  [AW-1:0] addr_q;
  reg  [IW-1:0] idx_q;
  reg           set_q;

  assign BUSY_OUT = active_q;

  always @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      active_q <= 1'b0;
      addr_q   <= {AW{1'b0}};
      idx_q    <= {IW{1'b0}};
      set_q    <= 1'b0;
    end else begin
      case (phase_q)
        ST_DECODE: begin
          active_q <= take;
          addr_q   <= field_addr;
          idx_q    <= field_idx;
          // Select bit 1 means clear, 0 means set.
          set_q    <= ~field_clear;
        end
        ST_READ: begin
          active_q <= active_q;
        end
        ST_MODIFY: begin
          active_q <= active_q;
        end
        ST_WRITE: begin
          // Cleared here so that an ignored word in the next slot leaves no trace.
          active_q <= 1'b0;
        end
        default: begin
          active_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  // An ignored or foreign word never strobes the read port, so no stray access occurs.
  always @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      RD_ADDR_OUT <= {AW{1'b0}};
      RD_EN_OUT   <= 1'b0;
    end else begin
      RD_EN_OUT <= take;
      if (take) begin
        RD_ADDR_OUT <= field_addr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data capture
  // ----------------------------------------------------------------
  // The register file must answer within the cycle that carries the read strobe; the
  // byte is taken at the close of the read phase and held through modify.
  reg  [DW-1:0] data_q;

  always @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      data_q <= {DW{1'b0}};
    end else if (in_read && active_q) begin
      data_q <= RD_DATA_IN;
    end
  end

  // ----------------------------------------------------------------
  // Bit modify
  // ----------------------------------------------------------------
  wire [DW-1:0] mod_data;

  bit_modify #(
    .W  (DW),
    .IW (IW)
  ) u_mod (
    .data_in  (data_q),
    .idx_in   (idx_q),
    .set_in   (set_q),
    .data_out (mod_data)
  );

  // ----------------------------------------------------------------
  // Register write port
  // ----------------------------------------------------------------
  wire          wr_fire;

  assign wr_fire = in_modify && active_q;

  always @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      WR_ADDR_OUT <= {AW{1'b0}};
      WR_DATA_OUT <= {DW{1'b0}};
      WR_EN_OUT   <= 1'b0;
    end else begin
      // The strobe stands during the write phase only; address and data hold after it.
      WR_EN_OUT <= wr_fire;
      if (wr_fire) begin
        WR_ADDR_OUT <= addr_q;
        WR_DATA_OUT <= mod_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Completion
  // ----------------------------------------------------------------
  // No status flag is touched here; completion is only reported as a one-cycle pulse.
  wire          done_d;

  assign done_d = in_write && active_q;

  always @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      DONE_OUT <= 1'b0;
    end else begin
      DONE_OUT <= done_d;
    end
  end

endmodule // bit_op_unit

// ---- verification/bit_op_unit_assertions.sv ----
// Checker for the bit set and clear unit.
`timescale 1ns/1ps
module bit_op_unit_chk (
  input wire        SYS_CLK_IN,
  input wire        RSTN_IN,
  input wire        INSTR_VALID_IN,
  input wire [15:0] INSTR_IN,
  input wire        INSTR_READY_OUT,
  input wire [7:0]  RD_ADDR_OUT,
  input wire        RD_EN_OUT,
  input wire [7:0]  RD_DATA_IN,
  input wire [7:0]  WR_ADDR_OUT,
  input wire [7:0]  WR_DATA_OUT,
  input wire        WR_EN_OUT,
  input wire        DONE_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  wire tk = INSTR_READY_OUT && INSTR_VALID_IN && INSTR_IN[15:12] == 4'h8;
  sequence rmw_s;
    ##1 RD_EN_OUT ##2 WR_EN_OUT ##1 DONE_OUT;
  endsequence
  sequence slot_s;
    ##1 !INSTR_READY_OUT [*3] ##1 INSTR_READY_OUT;
  endsequence
  chk_phase_order:
    assert property (tk |-> rmw_s) else $error("phase order wrong");
  chk_read_addr:
    assert property (tk |=> RD_ADDR_OUT == $past(INSTR_IN[7:0])) else $error("bad address");
  chk_clear_bit:
    assert property (tk && INSTR_IN[11] |-> ##3
      WR_DATA_OUT == ($past(RD_DATA_IN, 2) & ~(8'h01 << $past(INSTR_IN[10:8], 3))))
      else $error("bad clear");
  chk_set_bit:
    assert property (tk && !INSTR_IN[11] |-> ##3
      WR_DATA_OUT == ($past(RD_DATA_IN, 2) | (8'h01 << $past(INSTR_IN[10:8], 3))))
      else $error("bad set");
  chk_foreign_idle:
    assert property (INSTR_READY_OUT && !tk |-> ##3 !WR_EN_OUT) else $error("stray write");
  chk_write_addr:
    assert property (tk |-> ##3 WR_ADDR_OUT == $past(INSTR_IN[7:0], 3)) else $error("bad write address");
  chk_slot_cadence:
    assert property (INSTR_READY_OUT |-> slot_s) else $error("slot length wrong");
endmodule // bit_op_unit_chk
bind bit_op_unit bit_op_unit_chk u_chk (
  .SYS_CLK_IN      (SYS_CLK_IN),
  .RSTN_IN         (RSTN_IN),
  .INSTR_VALID_IN  (INSTR_VALID_IN),
  .INSTR_IN        (INSTR_IN),
  .INSTR_READY_OUT (INSTR_READY_OUT),
  .RD_ADDR_OUT     (RD_ADDR_OUT),
  .RD_EN_OUT       (RD_EN_OUT),
  .RD_DATA_IN      (RD_DATA_IN),
  .WR_ADDR_OUT     (WR_ADDR_OUT),
  .WR_DATA_OUT     (WR_DATA_OUT),
  .WR_EN_OUT       (WR_EN_OUT),
  .DONE_OUT        (DONE_OUT)
);

// ---- verification/bit_op_unit_bench.sv ----
// Self-checking bench for the bit set and clear unit.
`timescale 1ns/1ps
module bit_op_unit_bench;
  reg        clk = 1'b0, rstn = 1'b0, vld = 1'b0;
  reg [15:0] ins = 16'h0000;
  reg [7:0]  rdd = 8'h00;
  wire       rdy, ren, wen, busy, done;
  wire [7:0] ra, wa, wd;
  integer    mismatches = 0, num_checks = 0, i;
  always #2.5 clk = ~clk;
  bit_op_unit dut (.SYS_CLK_IN(clk), .RSTN_IN(rstn), .INSTR_VALID_IN(vld), .INSTR_IN(ins),
    .INSTR_READY_OUT(rdy), .RD_ADDR_OUT(ra), .RD_EN_OUT(ren), .RD_DATA_IN(rdd),
    .WR_ADDR_OUT(wa), .WR_DATA_OUT(wd), .WR_EN_OUT(wen), .BUSY_OUT(busy), .DONE_OUT(done));
  task cmp(input [7:0] a, input [7:0] e);
    begin
      num_checks = num_checks + 1;
      if (a !== e) begin
        mismatches = mismatches + 1;
        $display("mismatch t=%0t got %h exp %h", $time, a, e);
      end
    end
  endtask
  task step;
    begin
      @(posedge clk);
      #1;
    end
  endtask
  task op(input [15:0] w, input [7:0] r, input [7:0] e);
    begin
      while (rdy !== 1'b1) step;
      vld = 1'b1;
      ins = w;
      step;
      vld = 1'b0;
      rdd = r;
      cmp({5'h00, rdy, busy, ren}, 8'h03);
      cmp(ra, w[7:0]);
      step;
      // Read data is withdrawn after the read phase, so a late sample shows up.
      rdd = ~r;
      step;
      cmp({5'h00, rdy, busy, wen}, 8'h03);
      cmp(wa, w[7:0]);
      cmp(wd, e);
      step;
      cmp({4'h0, rdy, busy, wen, done}, 8'h09);
    end
  endtask
  task t_other;
    begin
      vld = 1'b1;
      ins = 16'h9f07;
      step;
      vld = 1'b0;
      cmp({6'h00, busy, ren}, 8'h00);
      step;
      step;
      cmp({6'h00, busy, wen}, 8'h00);
      step;
      // A bit instruction without its valid qualifier must not touch the register file.
      ins = 16'h8f07;
      step;
      cmp({6'h00, busy, ren}, 8'h00);
      step;
      step;
      cmp({6'h00, busy, wen}, 8'h00);
      step;
    end
  endtask
  task t_index;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        op({5'h11, i[2:0], 8'hff}, 8'hff, 8'hff ^ (8'h01 << i));
        op({5'h10, i[2:0], 8'h00}, 8'h00, 8'h01 << i);
      end
    end
  endtask
  task report_and_stop;
    begin
      if (mismatches == 0 && num_checks > 0) begin
        $display("TB: PASS");
      end else begin
        $display("TB: FAIL");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1 rstn = 1'b1;
    op(16'h8f07, 8'hc7, 8'h47);
    op(16'h8780, 8'h0a, 8'h8a);
    t_other;
    t_index;
    report_and_stop;
  end
  initial begin
    #2000;
    mismatches = mismatches + 1;
    report_and_stop;
  end
endmodule // bit_op_unit_bench
